//--- hw/msa_pkg.sv
// package: register indices, field layout, reset values and timing for the measurement sequencer
package msa_pkg;
  // timing
  localparam int CLK_HZ      = 20_000_000;
  localparam int US_CYC      = CLK_HZ / 1_000_000;
  localparam int DLY_STEP_MS = 2;
  localparam int DLY_STEP_US = DLY_STEP_MS * 1000;

  // register indices on the local register port
  localparam logic [3:0] IDX_CONFIG     = 4'h0;
  localparam logic [3:0] IDX_ADC_CFG    = 4'h1;
  localparam logic [3:0] IDX_SHUNT_CAL  = 4'h2;
  localparam logic [3:0] IDX_SHUNT      = 4'h3;
  localparam logic [3:0] IDX_BUS        = 4'h4;
  localparam logic [3:0] IDX_TEMP       = 4'h5;
  localparam logic [3:0] IDX_POWER      = 4'h6;
  localparam logic [3:0] IDX_DIAG       = 4'h7;
  localparam logic [3:0] IDX_SHUNT_UNDR = 4'h8;
  localparam logic [3:0] IDX_SHUNT_OVER = 4'h9;
  localparam logic [3:0] IDX_BUS_OVER   = 4'hA;
  localparam logic [3:0] IDX_BUS_UNDR   = 4'hB;
  localparam logic [3:0] IDX_TEMP_OVER  = 4'hC;
  localparam logic [3:0] IDX_PWR_OVER   = 4'hD;

  // reset values
  localparam logic [15:0] RST_CONFIG     = 16'h0000;
  localparam logic [15:0] RST_ADC_CFG    = 16'hFB68;
  localparam logic [15:0] RST_SHUNT_CAL  = 16'h1000;
  localparam logic [15:0] RST_SHUNT_UNDR = 16'h8000;
  localparam logic [15:0] RST_SHUNT_OVER = 16'h7FFF;
  localparam logic [15:0] RST_BUS_OVER   = 16'h7FFF;
  localparam logic [15:0] RST_BUS_UNDR   = 16'h0000;
  localparam logic [15:0] RST_TEMP_OVER  = 16'hFFFF;
  localparam logic [15:0] RST_PWR_OVER   = 16'h7FFF;

  // field positions
  localparam int F_MODE_LSB  = 12;
  localparam int F_BCT_LSB   = 9;
  localparam int F_SCT_LSB   = 6;
  localparam int F_TCT_LSB   = 3;
  localparam int F_AVG_LSB   = 0;
  localparam int F_DLY_LSB   = 6;
  localparam int F_CONT_BIT  = 3;
  localparam int D_LATCH     = 15;
  localparam int D_DONE_ALERT_ENABLE      = 14;
  localparam int D_SLOW      = 13;
  localparam int D_ALERT_POLARITY_SELECT      = 12;
  localparam int D_ARITHMETIC_OVERFLOW_FLAG    = 9;
  localparam int D_FAULT_LSB = 2;
  localparam int D_DONE      = 1;
  localparam int D_MEM       = 0;

  // channels
  localparam logic [1:0] CH_BUS   = 2'h0;
  localparam logic [1:0] CH_SHUNT = 2'h1;
  localparam logic [1:0] CH_TEMP  = 2'h2;
  localparam logic [1:0] CH_NONE  = 2'h3;

  // conversion times in microseconds and averaging shifts per code
  localparam logic [12:0] CT_US [8] = '{13'd50, 13'd84, 13'd150, 13'd280, 13'd540, 13'd1052, 13'd2074, 13'd4120};
  localparam logic [3:0]  AVG_SHIFT [8] = '{4'd0, 4'd2, 4'd4, 4'd6, 4'd7, 4'd8, 4'd9, 4'd10};

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV} msa_state_t;
endpackage

//--- hw/msa_sequencer.sv
// measurement sequencer, averaging, limit compare and alert pin control
// Operation
// - convert only inputs enabled by mode field
// - without averaging, each result stored at its end
// - per-input conversion time, 50 us to 4.12 ms
// - enabled inputs converted strictly one after another
// - averaging accumulates, outputs load after final pass
// - outputs hold until next completed result
// - continuous mode repeats forever
// - triggered mode runs once then shuts down
// - mode write aborts and restarts sequence
// - done flag set after whole sequence
// - done flag clears on non-shutdown mode write, diag read
// - power computed in parallel, no added time
// - start delay 0 to 510 ms, 2 ms steps
// - averaging 1 to 1024, common to inputs
// - filter settles within one conversion window
// - compare results to limits, set fault bits
// - latched alert held until diag read
// - done alert option, flag always updated
// - averaged-compare option uses averaged results
// - alert active low, polarity bit inverts
// - overflow flag set, never drives alert
// - trim memory ok bit reads one while trim_intact is high
// - trigger from shutdown completes then shuts down
// - power zero when calibration is zero
`timescale 1ns/1ps
module msa_sequencer #(
  parameter int CYC_PER_US = msa_pkg::US_CYC,
  parameter int ACC_W      = 26
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [3:0]  reg_sel,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // converter front end
  output logic             adc_busy,
  output logic      [1:0]  adc_chan,
  input  wire logic [15:0] adc_sample,
  input  wire logic        trim_intact,
  // open-drain alert pin
  output logic             alert_out,
  output logic             alert_oe
);
  msa_pkg::msa_state_t st;
  logic        [15:0] config_reg;
  logic        [15:0] adc_cfg;
  logic        [15:0] shunt_cal;
  logic        [15:0] shunt_under_limit;
  logic        [15:0] shunt_over_limit;
  logic        [15:0] bus_over_limit;
  logic        [15:0] bus_under_limit;
  logic        [15:0] temperature_over_limit;
  logic        [15:0] power_over_limit;
  logic        [3:0]  diag_ctl;
  logic        [15:0] res [3];
  logic        [15:0] smp [3];
  logic signed [15:0] power;
  logic        [5:0]  fault;
  logic               conversion_done_flag;
  logic               arithmetic_overflow_flag;
  logic               trim_memory_ok_flag;
  logic        [1:0]  ch;
  logic        [19:0] us_cnt;
  logic        [15:0] pre;
  logic        [10:0] pass;
  logic               tick;
  logic               conv_end;
  logic               last_pass;
  logic               done_set;
  logic               mode_wr;
  logic               diag_rd;
  logic        [2:0]  en;
  logic        [3:0]  shift;
  logic        [10:0] pass_max;
  logic        [1:0]  first_ch;
  logic        [1:0]  next_ch;
  logic        [2:0]  ct_code;
  logic        [5:0]  now_fault;
  logic               alert_act;
  logic signed [31:0] prod;

  // first enabled channel at or after s
  function automatic logic [1:0] first_from(input logic [2:0] s, input logic [2:0] e);
    first_from = msa_pkg::CH_NONE;
    for (int i = 2; i >= 0; i--) begin
      if (i >= int'(s) && e[i]) begin
        first_from = 2'(i);
      end
    end
  endfunction

  assign mode_wr  = reg_wr && reg_sel == msa_pkg::IDX_ADC_CFG;
  assign diag_rd  = reg_rd && reg_sel == msa_pkg::IDX_DIAG;
  assign en       = adc_cfg[msa_pkg::F_MODE_LSB +: 3];
  assign shift    = msa_pkg::AVG_SHIFT[adc_cfg[msa_pkg::F_AVG_LSB +: 3]];
  assign pass_max = 11'((11'd1 << shift) - 11'd1);
  assign first_ch = first_from(3'd0, en);
  assign next_ch  = first_from(3'(ch) + 3'd1, en);
  assign tick     = pre == 16'(CYC_PER_US - 1);
  assign conv_end = st == msa_pkg::ST_CONV && tick && us_cnt == 20'd1;
  assign last_pass = pass == pass_max;
  assign done_set = conv_end && next_ch == msa_pkg::CH_NONE && last_pass && !mode_wr;

  always_comb begin
    unique case (ch)
      msa_pkg::CH_BUS:   ct_code = adc_cfg[msa_pkg::F_BCT_LSB +: 3];
      msa_pkg::CH_SHUNT: ct_code = adc_cfg[msa_pkg::F_SCT_LSB +: 3];
      default:           ct_code = adc_cfg[msa_pkg::F_TCT_LSB +: 3];
    endcase
  end

  // microsecond prescaler
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre <= 16'h0000;
    end else if (tick || mode_wr) begin
      pre <= 16'h0000;
    end else begin
      pre <= pre + 16'h0001;
    end
  end

  // sequencer state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st     <= msa_pkg::ST_IDLE;
      ch     <= msa_pkg::CH_BUS;
      us_cnt <= 20'h00000;
      pass   <= 11'h000;
    end else if (mode_wr) begin
      pass   <= 11'h000;
      ch     <= first_from(3'd0, reg_wdata[msa_pkg::F_MODE_LSB +: 3]);
      us_cnt <= 20'(config_reg[msa_pkg::F_DLY_LSB +: 8] * msa_pkg::DLY_STEP_US);
      if (reg_wdata[msa_pkg::F_MODE_LSB +: 3] == 3'h0) begin
        st <= msa_pkg::ST_IDLE;
      end else begin
        st <= msa_pkg::ST_DELAY;
      end
    end else begin
      unique case (st)
        msa_pkg::ST_IDLE: begin
          us_cnt <= 20'h00000;
        end
        msa_pkg::ST_DELAY: begin
          if (us_cnt == 20'h00000) begin
            st     <= msa_pkg::ST_CONV;
            us_cnt <= 20'(msa_pkg::CT_US[ct_code]);
          end else if (tick) begin
            us_cnt <= us_cnt - 20'h00001;
          end
        end
        msa_pkg::ST_CONV: begin
          if (conv_end) begin
            if (next_ch != msa_pkg::CH_NONE) begin
              ch <= next_ch;
              st <= msa_pkg::ST_DELAY;
            end else if (!last_pass) begin
              pass <= pass + 11'h001;
              ch   <= first_ch;
              st   <= msa_pkg::ST_DELAY;
            end else begin
              pass <= 11'h000;
              ch   <= first_ch;
              if (adc_cfg[msa_pkg::F_MODE_LSB + msa_pkg::F_CONT_BIT]) begin
                st <= msa_pkg::ST_DELAY;
              end else begin
                st <= msa_pkg::ST_IDLE;
              end
            end
          end else if (tick) begin
            us_cnt <= us_cnt - 20'h00001;
          end
        end
        default: st <= msa_pkg::ST_IDLE;
      endcase
    end
  end

  // the next window is loaded from the current channel's adc_cfg conversion-time field once the DELAY count reaches zero
  assign adc_busy = st == msa_pkg::ST_CONV;
  assign adc_chan = ch;

  // per-channel sample, accumulator and output register
  for (genvar g = 0; g < 3; g++) begin : g_chan
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] sum;
    assign sum = acc + ACC_W'($signed(adc_sample));
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        acc    <= '0;
        res[g] <= 16'h0000;
        smp[g] <= 16'h0000;
      end else if (mode_wr) begin
        acc <= '0;
      end else if (conv_end && ch == 2'(g)) begin
        smp[g] <= adc_sample;
        if (last_pass) begin
          res[g] <= 16'(sum >>> shift);
          acc    <= '0;
        end else begin
          acc <= sum;
        end
      end
    end
  end

  // power engine runs beside the sequencer
  assign prod = $signed(res[msa_pkg::CH_SHUNT]) * $signed({1'b0, res[msa_pkg::CH_BUS][15:1]});
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power <= 16'sh0000;
    end else if (shunt_cal == 16'h0000) begin
      power <= 16'sh0000;
    end else begin
      power <= prod[30:15];
    end
  end

  // limit compare
  always_comb begin
    logic [15:0] s_sh;
    logic [15:0] s_bu;
    logic [15:0] s_tp;
    s_sh = diag_ctl[1] ? res[msa_pkg::CH_SHUNT] : smp[msa_pkg::CH_SHUNT];
    s_bu = diag_ctl[1] ? res[msa_pkg::CH_BUS] : smp[msa_pkg::CH_BUS];
    s_tp = diag_ctl[1] ? res[msa_pkg::CH_TEMP] : smp[msa_pkg::CH_TEMP];
    now_fault[5] = s_tp > temperature_over_limit;
    now_fault[4] = $signed(s_sh) > $signed(shunt_over_limit);
    now_fault[3] = $signed(s_sh) < $signed(shunt_under_limit);
    now_fault[2] = s_bu > bus_over_limit;
    now_fault[1] = s_bu < bus_under_limit;
    now_fault[0] = power > $signed(power_over_limit);
  end

  // status flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault                    <= 6'h00;
      conversion_done_flag     <= 1'b0;
      arithmetic_overflow_flag <= 1'b0;
      trim_memory_ok_flag      <= 1'b0;
    end else begin
      trim_memory_ok_flag <= trim_intact;
      if (diag_ctl[3]) begin
        fault <= (fault & ~{6{diag_rd}}) | now_fault;
      end else begin
        fault <= now_fault;
      end
      if (done_set) begin
        conversion_done_flag <= 1'b1;
      end else if (diag_rd || (mode_wr && reg_wdata[msa_pkg::F_MODE_LSB +: 3] != 3'h0)) begin
        conversion_done_flag <= 1'b0;
      end
      if (shunt_cal != 16'h0000 && prod[31] != prod[30]) begin
        arithmetic_overflow_flag <= 1'b1;
      end else if (diag_rd) begin
        arithmetic_overflow_flag <= 1'b0;
      end
    end
  end

  // alert pin: drive low while the asserted level is low
  assign alert_act = |fault || (diag_ctl[2] && conversion_done_flag);
  assign alert_out = 1'b0;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alert_oe <= 1'b0;
    end else begin
      alert_oe <= diag_ctl[0] ? !alert_act : alert_act;
    end
  end

  // register writes; diag_ctl = {latch, done alert, averaged compare, polarity}
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      config_reg             <= msa_pkg::RST_CONFIG;
      adc_cfg                <= msa_pkg::RST_ADC_CFG;
      shunt_cal              <= msa_pkg::RST_SHUNT_CAL;
      shunt_under_limit      <= msa_pkg::RST_SHUNT_UNDR;
      shunt_over_limit       <= msa_pkg::RST_SHUNT_OVER;
      bus_over_limit         <= msa_pkg::RST_BUS_OVER;
      bus_under_limit        <= msa_pkg::RST_BUS_UNDR;
      temperature_over_limit <= msa_pkg::RST_TEMP_OVER;
      power_over_limit       <= msa_pkg::RST_PWR_OVER;
      diag_ctl               <= 4'h0;
    end else if (reg_wr) begin
      unique case (reg_sel)
        msa_pkg::IDX_CONFIG:     config_reg             <= reg_wdata;
        msa_pkg::IDX_ADC_CFG:    adc_cfg                <= reg_wdata;
        msa_pkg::IDX_SHUNT_CAL:  shunt_cal              <= reg_wdata;
        msa_pkg::IDX_SHUNT_UNDR: shunt_under_limit      <= reg_wdata;
        msa_pkg::IDX_SHUNT_OVER: shunt_over_limit       <= reg_wdata;
        msa_pkg::IDX_BUS_OVER:   bus_over_limit         <= reg_wdata;
        msa_pkg::IDX_BUS_UNDR:   bus_under_limit        <= reg_wdata;
        msa_pkg::IDX_TEMP_OVER:  temperature_over_limit <= reg_wdata;
        msa_pkg::IDX_PWR_OVER:   power_over_limit       <= reg_wdata;
        msa_pkg::IDX_DIAG:       diag_ctl               <= reg_wdata[msa_pkg::D_ALERT_POLARITY_SELECT +: 4];
        default:                 diag_ctl               <= diag_ctl;
      endcase
    end
  end

  // registered read data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_sel)
        msa_pkg::IDX_CONFIG:     reg_rdata <= config_reg;
        msa_pkg::IDX_ADC_CFG:    reg_rdata <= adc_cfg;
        msa_pkg::IDX_SHUNT_CAL:  reg_rdata <= shunt_cal;
        msa_pkg::IDX_SHUNT:      reg_rdata <= res[msa_pkg::CH_SHUNT];
        msa_pkg::IDX_BUS:        reg_rdata <= res[msa_pkg::CH_BUS];
        msa_pkg::IDX_TEMP:       reg_rdata <= res[msa_pkg::CH_TEMP];
        msa_pkg::IDX_POWER:      reg_rdata <= power;
        msa_pkg::IDX_DIAG:       reg_rdata <= {diag_ctl, 2'b00, arithmetic_overflow_flag, 1'b0, fault,
                                               conversion_done_flag, trim_memory_ok_flag};
        msa_pkg::IDX_SHUNT_UNDR: reg_rdata <= shunt_under_limit;
        msa_pkg::IDX_SHUNT_OVER: reg_rdata <= shunt_over_limit;
        msa_pkg::IDX_BUS_OVER:   reg_rdata <= bus_over_limit;
        msa_pkg::IDX_BUS_UNDR:   reg_rdata <= bus_under_limit;
        msa_pkg::IDX_TEMP_OVER:  reg_rdata <= temperature_over_limit;
        msa_pkg::IDX_PWR_OVER:   reg_rdata <= power_over_limit;
        default:                 reg_rdata <= 16'h0000;
      endcase
    end
  end

  a_shutdown_write: assert property (@(posedge clk) disable iff (rst)
    mode_wr && reg_wdata[14:12] == 3'h0 |=> st == msa_pkg::ST_IDLE && !adc_busy)
    else $error("shutdown write did not stop the sequence");
  a_restart_write: assert property (@(posedge clk) disable iff (rst)
    mode_wr && reg_wdata[14:12] != 3'h0 |=> st == msa_pkg::ST_DELAY && pass == 11'h000)
    else $error("mode write did not restart the sequence");
  a_done_set: assert property (@(posedge clk) disable iff (rst)
    done_set |=> conversion_done_flag)
    else $error("done flag not set at sequence end");
  a_done_clear: assert property (@(posedge clk) disable iff (rst)
    diag_rd && !done_set |=> !conversion_done_flag)
    else $error("done flag not cleared by diag read");
  a_trig_stop: assert property (@(posedge clk) disable iff (rst)
    done_set && !adc_cfg[15] && !mode_wr |=> st == msa_pkg::ST_IDLE [*3])
    else $error("triggered sequence did not shut down");
  a_alert_level: assert property (@(posedge clk) disable iff (rst)
    ##1 alert_oe == ($past(diag_ctl[0]) ^ $past(alert_act)))
    else $error("alert pin level wrong for polarity");
  a_latch_hold: assert property (@(posedge clk) disable iff (rst)
    diag_ctl[3] && |fault && !diag_rd && !reg_wr |=> |fault)
    else $error("latched alert released without diag read");
  a_power_zero: assert property (@(posedge clk) disable iff (rst)
    shunt_cal == 16'h0000 && !reg_wr |=> ##1 power == 16'sh0000)
    else $error("power not zero with zero calibration");
  a_output_hold: assert property (@(posedge clk) disable iff (rst)
    !conv_end |=> $stable(res[msa_pkg::CH_BUS]))
    else $error("bus result changed without a completed conversion");
  a_chan_enabled: assert property (@(posedge clk) disable iff (rst)
    adc_busy |-> en[adc_chan])
    else $error("conversion window on a disabled input");
  a_delay_hold: assert property (@(posedge clk) disable iff (rst)
    st == msa_pkg::ST_DELAY && us_cnt != 20'h00000 && !mode_wr |=> !adc_busy)
    else $error("conversion started before the delay ran out");
  a_trim_flag: assert property (@(posedge clk) disable iff (rst)
    trim_intact |=> trim_memory_ok_flag)
    else $error("trim memory flag not set while memory intact");
  a_alert_fault: assert property (@(posedge clk) disable iff (rst)
    |fault && !diag_ctl[0] |=> alert_oe)
    else $error("fault present but alert pin not pulled");
  a_avg_compare: assert property (@(posedge clk) disable iff (rst)
    diag_ctl[1] && res[msa_pkg::CH_BUS] > bus_over_limit |=> fault[2])
    else $error("averaged bus result over limit not flagged");
endmodule // msa_sequencer

//--- test/msa_adc_model.sv
// front-end model: per-channel input level during conversion windows
`timescale 1ns/1ps
module msa_adc_model (
  // clock
  input  wire logic        clk,
  // converter control
  input  wire logic        adc_busy,
  input  wire logic [1:0]  adc_chan,
  // programmed input levels
  input  wire logic [15:0] lvl_bus,
  input  wire logic [15:0] lvl_shunt,
  input  wire logic [15:0] lvl_temp,
  // sample to the sequencer
  output logic      [15:0] adc_sample
);
  logic [15:0] last;
  logic [15:0] lvl;

  always_comb begin
    case (adc_chan)
      msa_pkg::CH_BUS:   lvl = lvl_bus;
      msa_pkg::CH_SHUNT: lvl = lvl_shunt;
      default:           lvl = lvl_temp;
    endcase
  end

  // settled through the whole window, inverted junk outside it
  assign adc_sample = adc_busy ? lvl : ~last;

  always_ff @(posedge clk) begin
    if (adc_busy) begin
      last <= lvl;
    end
  end
endmodule // msa_adc_model

//--- test/measurement_sequencer_alert_tb_top.sv
// self-checking bench for the measurement sequencer
`timescale 1ns/1ps
module measurement_sequencer_alert_tb_top;
  typedef struct {bit wr; logic [3:0] sel; logic [15:0] dat; logic [15:0] exp;} msa_row_t;

  logic        clk;
  logic        rst;
  logic        reg_wr;
  logic        reg_rd;
  logic        trim_intact;
  logic        adc_busy;
  logic        alert_oe;
  logic        alert_out;
  logic        was_busy;
  logic [3:0]  reg_sel;
  logic [1:0]  adc_chan;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [15:0] adc_sample;
  logic [15:0] lvl_bus;
  logic [15:0] lvl_shunt;
  logic [15:0] lvl_temp;
  int          miscompares;
  int          tests_run;
  int          windows;
  int          cnt [4];

  // ordinary register cases: reset values, write-back, refused writes
  msa_row_t rows [15] = '{
    '{0, 4'h8, 16'h0000, 16'h8000}, '{0, 4'h9, 16'h0000, 16'h7FFF}, '{0, 4'hA, 16'h0000, 16'h7FFF},
    '{0, 4'hB, 16'h0000, 16'h0000}, '{0, 4'hC, 16'h0000, 16'hFFFF}, '{0, 4'hD, 16'h0000, 16'h7FFF},
    '{0, 4'h2, 16'h0000, 16'h1000}, '{0, 4'h1, 16'h0000, 16'hFB68}, '{0, 4'h0, 16'h0000, 16'h0000},
    '{0, 4'h7, 16'h0000, 16'h0001}, '{0, 4'hE, 16'h0000, 16'h0000}, '{1, 4'h8, 16'h8001, 16'h8001},
    '{1, 4'hD, 16'h7FFE, 16'h7FFE}, '{1, 4'h4, 16'hABCD, 16'h0000}, '{1, 4'hE, 16'h1111, 16'h0000}};

  msa_sequencer #(.CYC_PER_US(1)) i_dut (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .adc_busy(adc_busy), .adc_chan(adc_chan), .adc_sample(adc_sample),
    .trim_intact(trim_intact), .alert_out(alert_out), .alert_oe(alert_oe));

  msa_adc_model i_adc (
    .clk(clk), .adc_busy(adc_busy), .adc_chan(adc_chan), .lvl_bus(lvl_bus), .lvl_shunt(lvl_shunt),
    .lvl_temp(lvl_temp), .adc_sample(adc_sample));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // window lengths per channel and number of windows started
  always @(posedge clk) begin
    if (adc_busy) begin
      cnt[adc_chan] += 1;
      if (!was_busy) begin
        windows += 1;
      end
    end
    was_busy = adc_busy;
  end

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] sel, input logic [15:0] dat);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_sel   <= sel;
    reg_wdata <= dat;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] sel, input logic [15:0] exp, input logic [15:0] m = 16'hFFFF);
    @(posedge clk);
    reg_rd  <= 1'b1;
    reg_sel <= sel;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    #1;
    chk(reg_rdata & m, exp);
  endtask

  task automatic clr;
    #1;
    windows = 0;
    cnt = '{0, 0, 0, 0};
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // wait until a sequence ran and the converter has gone quiet
  task automatic settle;
    int q;
    q = 0;
    while (q < 10) begin
      tick(1);
      q = (adc_busy || windows == 0) ? 0 : q + 1;
    end
  endtask

  task automatic run(input logic [15:0] cfg);
    clr;
    wr(4'h1, cfg);
    settle;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    stop_test;
  end

  initial begin
    rst         = 1'b1;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_sel     = 4'h0;
    reg_wdata   = 16'h0000;
    trim_intact = 1'b1;
    lvl_bus     = 16'h0200;
    lvl_shunt   = 16'h0100;
    lvl_temp    = 16'h0C80;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 15; i++) begin
      if (rows[i].wr) begin
        wr(rows[i].sel, rows[i].dat);
      end
      rd(rows[i].sel, rows[i].exp);
    end
    $display("registers done");
    run(16'h7210);
    chk(16'(cnt[0]), 16'd84);
    chk(16'(cnt[1]), 16'd50);
    chk(16'(cnt[2]), 16'd150);
    rd(4'h4, 16'h0200);
    rd(4'h3, 16'h0100);
    rd(4'h5, 16'h0C80);
    rd(4'h6, 16'h0002);
    rd(4'h7, 16'h0003);
    tick(60);
    chk(16'(windows), 16'd3);
    wr(4'h2, 16'h0000);
    run(16'h7210);
    rd(4'h6, 16'h0000);
    wr(4'h2, 16'h1000);
    $display("sequence done");
    lvl_bus <= 16'h0300;
    clr;
    wr(4'h1, 16'h1001);
    while (windows == 0 || adc_busy) tick(1);
    rd(4'h4, 16'h0200);
    rd(4'h7, 16'h0001);
    settle;
    chk(16'(cnt[0]), 16'd200);
    rd(4'h4, 16'h0300);
    $display("averaging done");
    wr(4'h0, 16'h0040);
    clr;
    wr(4'h1, 16'h1000);
    tick(1990);
    chk(16'(windows), 16'd0);
    settle;
    chk(16'(windows), 16'd1);
    wr(4'h0, 16'h0000);
    $display("delay done");
    clr;
    wr(4'h1, 16'h9000);
    while (windows < 3) tick(1);
    tick(20);
    wr(4'h1, 16'h9000);
    chk(16'(adc_busy), 16'h0000);
    clr;
    while (windows == 0 || adc_busy) tick(1);
    tick(2);
    wr(4'h1, 16'h0000);
    rd(4'h7, 16'h0003);
    rd(4'h7, 16'h0001);
    clr;
    tick(100);
    chk(16'(windows), 16'd0);
    $display("continuous done");
    wr(4'hA, 16'h0100);
    lvl_bus <= 16'h1234;
    run(16'h1000);
    rd(4'h7, 16'h0013);
    chk(16'(alert_oe), 16'h0001);
    chk(16'(alert_out), 16'h0000);
    wr(4'h7, 16'h1000);
    tick(2);
    chk(16'(alert_oe), 16'h0000);
    wr(4'h7, 16'h8000);
    wr(4'hA, 16'h7FFF);
    tick(3);
    chk(16'(alert_oe), 16'h0001);
    rd(4'h7, 16'h8001, 16'hFFEF);
    tick(2);
    chk(16'(alert_oe), 16'h0000);
    wr(4'h7, 16'h4000);
    run(16'h1000);
    chk(16'(alert_oe), 16'h0001);
    rd(4'h7, 16'h4003);
    tick(2);
    chk(16'(alert_oe), 16'h0000);
    wr(4'h7, 16'h2000);
    wr(4'hA, 16'h0100);
    lvl_bus <= 16'h0050;
    clr;
    wr(4'h1, 16'h1001);
    while (windows == 0 || adc_busy) tick(1);
    rd(4'h7, 16'h2011);
    settle;
    rd(4'h7, 16'h2003);
    wr(4'hA, 16'h7FFF);
    wr(4'h7, 16'h0000);
    @(posedge clk);
    trim_intact <= 1'b0;
    rd(4'h7, 16'h0000);
    trim_intact <= 1'b1;
    $display("alert done");
    wr(4'h1, 16'h9000);
    @(posedge clk);
    rst <= 1'b1;
    tick(2);
    chk(16'(adc_busy), 16'h0000);
    @(posedge clk);
    rst <= 1'b0;
    rd(4'h8, 16'h8000);
    $display("reset done");
    stop_test;
  end
endmodule // measurement_sequencer_alert_tb_top
